// ==== src/mmp_consts.vh ====
/*
  Constants for the medium port block: register offsets, field positions,
  reset values and timing counts.
  Assumes inclusion by bare name from the design file.
*/
`ifndef MMP_CONSTS_VH
`define MMP_CONSTS_VH

`define MMP_ADDR_W          8
`define MMP_OFF_CFG3        8'h00
`define MMP_OFF_MEDIUM      8'h04
`define MMP_OFF_STATUS      8'h08
`define MMP_OFF_TXCTL       8'h0C
`define MMP_OFF_RXHDR       8'h10
`define MMP_OFF_RXDATA      8'h14
`define MMP_OFF_MDCDIV      8'h18

`define MMP_CFG3_MII_BIT    1
`define MMP_CFG3_RESET      8'h00

`define MMP_MED_AUTO        2'h0
`define MMP_MED_COAX        2'h1
`define MMP_MED_MII         2'h2
`define MMP_MED_UTP         2'h3

`define MMP_ISF_BIT         5
`define MMP_MDC_DIV_RESET   8'h04

`define MMP_RESP_OKAY       2'h0
`define MMP_RESP_SLVERR     2'h2

`endif

// ==== src/mmp_medium_port.v ====
/*
  Medium-side port of the Ethernet controller: MII nibble port, AUI
  selection, coax power control, link/duplex status and MDC generation,
  with an AXI4-Lite register slave.
  Assumes PHY clocks slower than aclk/2, sampled via two flip-flops.
*/
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`include "mmp_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module mmp_medium_port #(
  parameter MDC_DIV_W = 8
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        txc,
  output reg         txen,
  output reg  [3:0]  txd,
  input  wire        rxc,
  input  wire [3:0]  rxd,
  input  wire        rxdv,
  input  wire        rxer,
  input  wire        col,
  input  wire        ext_phy_link_state,
  input  wire        ext_phy_duplex_state,
  input  wire        utp_link,
  input  wire        attach_collision,
  output reg         mdc,
  input  wire        mdio_in,
  output reg         mdio_out,
  output reg         mdio_oe_n,
  output reg         medium_mii_sel,
  output reg         medium_utp_sel
);

  // Two-flop synchronisers; stage one read only by stage two
  reg [11:0] sync1_ff;
  reg [11:0] sync2_ff;
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff <= 12'h000;
      sync2_ff <= 12'h000;
    end else begin
      sync1_ff <= {mdio_in, attach_collision, utp_link, ext_phy_duplex_state,
                   ext_phy_link_state, col, rxer, rxdv, rxc, txc, rxd[0],
                   1'b0};
      sync2_ff <= sync1_ff;
    end
  end
  wire       s_rxd0   = sync2_ff[1];
  wire       s_txc    = sync2_ff[2];
  wire       s_rxc    = sync2_ff[3];
  wire       s_rxdv   = sync2_ff[4];
  wire       s_rxer   = sync2_ff[5];
  wire       s_col    = sync2_ff[6];
  wire       s_link   = sync2_ff[7];
  wire       s_fdup   = sync2_ff[8];
  wire       s_utp    = sync2_ff[9];
  wire       s_acol   = sync2_ff[10];
  wire       s_mdio   = sync2_ff[11];

  reg [3:0] rxd_s1_ff;
  reg [3:0] rxd_s2_ff;
  always @(posedge aclk) begin
    if (!aresetn) begin
      rxd_s1_ff <= 4'h0;
      rxd_s2_ff <= 4'h0;
    end else begin
      rxd_s1_ff <= rxd;
      rxd_s2_ff <= rxd_s1_ff;
    end
  end

  // Edge detect on the synchronised link clocks
  reg txc_d_ff;
  reg rxc_d_ff;
  always @(posedge aclk) begin
    if (!aresetn) begin
      txc_d_ff <= 1'b0;
      rxc_d_ff <= 1'b0;
    end else begin
      txc_d_ff <= s_txc;
      rxc_d_ff <= s_rxc;
    end
  end
  wire txc_fall = txc_d_ff & ~s_txc;
  wire rxc_rise = s_rxc & ~rxc_d_ff;

  // Registers
  reg [7:0] config_register_three_ff;
  reg [1:0] medium_ff;
  reg       speed100_ff;
  reg [MDC_DIV_W-1:0] mdc_div_ff;
  reg       tx_go_ff;
  reg [3:0] tx_nib_ff;
  reg       tx_last_ff;
  reg       tx_busy_ff;
  reg [15:0] rx_header_status_ff;
  reg       rx_hdr_rd_ff;
  reg [3:0] rx_nib_ff;
  reg       rx_nib_new_ff;
  reg       col_seen_ff;

  wire mii_mode = config_register_three_ff[`MMP_CFG3_MII_BIT];

  // Medium selection
  reg nxt_mii_sel;
  reg nxt_utp_sel;
  reg nxt_coax_pwr;
  always @* begin
    nxt_mii_sel  = 1'b0;
    nxt_utp_sel  = 1'b0;
    nxt_coax_pwr = 1'b0;
    case (medium_ff)
      `MMP_MED_COAX: nxt_coax_pwr = ~mii_mode & ~s_rxd0;
      `MMP_MED_MII:  nxt_mii_sel  = mii_mode;
      `MMP_MED_UTP:  nxt_utp_sel  = 1'b1;
      default: begin
        if (s_utp)
          nxt_utp_sel = 1'b1;
        else if (mii_mode)
          nxt_mii_sel = s_link;
        else
          nxt_coax_pwr = ~s_rxd0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      medium_mii_sel <= 1'b0;
      medium_utp_sel <= 1'b0;
    end else begin
      medium_mii_sel <= nxt_mii_sel;
      medium_utp_sel <= nxt_utp_sel;
    end
  end

  // Transmit: nibble changes on TXC fall so PHY samples stable on rise
  always @(posedge aclk) begin
    if (!aresetn) begin
      txen       <= 1'b0;
      txd        <= 4'h0;
      tx_busy_ff <= 1'b0;
    end else if (!mii_mode) begin
      txen       <= 1'b0;
      txd        <= {3'h0, nxt_coax_pwr};
      tx_busy_ff <= 1'b0;
    end else if (txc_fall) begin
      if (tx_go_ff) begin
        txen       <= 1'b1;
        txd        <= tx_nib_ff;
        tx_busy_ff <= 1'b1;
      end else begin
        txen       <= 1'b0;
        txd        <= 4'h0;
        tx_busy_ff <= 1'b0;
      end
    end
  end

  // Receive on rising RXC; MII receive inputs ignored in AUI mode, rxd[0] still read for coax power
  wire rx_take = mii_mode & rxc_rise;
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_header_status_ff <= 16'h0000;
      rx_nib_ff           <= 4'h0;
      rx_nib_new_ff       <= 1'b0;
    end else begin
      if (rx_take & s_rxdv) begin
        rx_nib_ff     <= rxd_s2_ff;
        rx_nib_new_ff <= 1'b1;
      end else if (rx_hdr_rd_ff) begin
        rx_nib_new_ff <= 1'b0;
      end
      // Set wins over read-clear
      if (rx_take & s_rxdv & s_rxer & speed100_ff)
        rx_header_status_ff[`MMP_ISF_BIT] <= 1'b1;
      else if (rx_hdr_rd_ff)
        rx_header_status_ff[`MMP_ISF_BIT] <= 1'b0;
    end
  end
  wire invalid_symbol_flag = rx_header_status_ff[`MMP_ISF_BIT];

  always @(posedge aclk) begin
    if (!aresetn)
      col_seen_ff <= 1'b0;
    else
      col_seen_ff <= mii_mode ? (s_col & txen) : s_acol;
  end

  // MDC divider; MDIO released (oe_n high) by default
  reg [MDC_DIV_W-1:0] mdc_cnt_ff;
  always @(posedge aclk) begin
    if (!aresetn) begin
      mdc_cnt_ff <= {MDC_DIV_W{1'b0}};
      mdc        <= 1'b0;
      mdio_out   <= 1'b0;
      mdio_oe_n  <= 1'b1;
    end else if (mdc_cnt_ff >= mdc_div_ff) begin
      mdc_cnt_ff <= {MDC_DIV_W{1'b0}};
      mdc        <= ~mdc;
    end else begin
      mdc_cnt_ff <= mdc_cnt_ff + {{(MDC_DIV_W-1){1'b0}}, 1'b1};
    end
  end

  // AXI4-Lite slave
  reg [7:0]  aw_addr_ff;
  reg        aw_have_ff;
  reg [31:0] w_data_ff;
  reg [3:0]  w_strb_ff;
  reg        w_have_ff;

  function decode_ok;
    input [7:0] a;
    begin
      decode_ok = (a == `MMP_OFF_CFG3)  || (a == `MMP_OFF_MEDIUM) ||
                  (a == `MMP_OFF_STATUS) || (a == `MMP_OFF_TXCTL) ||
                  (a == `MMP_OFF_RXHDR) || (a == `MMP_OFF_RXDATA) ||
                  (a == `MMP_OFF_MDCDIV);
    end
  endfunction

  wire do_write = aw_have_ff & w_have_ff & ~s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `MMP_RESP_OKAY;
      aw_have_ff    <= 1'b0;
      w_have_ff     <= 1'b0;
      aw_addr_ff    <= 8'h00;
      w_data_ff     <= 32'h0000_0000;
      w_strb_ff     <= 4'h0;
      config_register_three_ff <= `MMP_CFG3_RESET;
      medium_ff     <= `MMP_MED_AUTO;
      speed100_ff   <= 1'b1;
      mdc_div_ff    <= `MMP_MDC_DIV_RESET;
      tx_go_ff      <= 1'b0;
      tx_nib_ff     <= 4'h0;
      tx_last_ff    <= 1'b0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_addr_ff    <= {s_axi_awaddr[7:2], 2'b00};
        aw_have_ff    <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_data_ff    <= s_axi_wdata;
        w_strb_ff    <= s_axi_wstrb;
        w_have_ff    <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= decode_ok(aw_addr_ff) ? `MMP_RESP_OKAY
                                               : `MMP_RESP_SLVERR;
        aw_have_ff   <= 1'b0;
        w_have_ff    <= 1'b0;
        if (w_strb_ff[0]) begin
          case (aw_addr_ff)
            `MMP_OFF_CFG3:   config_register_three_ff <= w_data_ff[7:0];
            `MMP_OFF_MEDIUM: begin
              medium_ff   <= w_data_ff[1:0];
              speed100_ff <= w_data_ff[4];
            end
            `MMP_OFF_TXCTL: begin
              tx_nib_ff  <= w_data_ff[3:0];
              tx_go_ff   <= w_data_ff[4];
              tx_last_ff <= w_data_ff[5];
            end
            `MMP_OFF_MDCDIV: mdc_div_ff <= w_data_ff[MDC_DIV_W-1:0];
            default: begin
            end
          endcase
        end
      end else if (tx_last_ff & txc_fall & tx_go_ff) begin
        tx_go_ff   <= 1'b0;
        tx_last_ff <= 1'b0;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `MMP_RESP_OKAY;
      rx_hdr_rd_ff  <= 1'b0;
    end else begin
      rx_hdr_rd_ff <= 1'b0;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= decode_ok({s_axi_araddr[7:2], 2'b00}) ?
                         `MMP_RESP_OKAY : `MMP_RESP_SLVERR;
        case ({s_axi_araddr[7:2], 2'b00})
          `MMP_OFF_CFG3:   s_axi_rdata <= {24'h0, config_register_three_ff};
          `MMP_OFF_MEDIUM: s_axi_rdata <= {27'h0, speed100_ff, 2'h0,
                                           medium_ff};
          `MMP_OFF_STATUS: s_axi_rdata <= {23'h0, s_mdio, txd[0], s_rxd0,
                                           col_seen_ff, tx_busy_ff,
                                           s_utp, s_fdup, s_link};
          `MMP_OFF_TXCTL:  s_axi_rdata <= {26'h0, tx_last_ff, tx_go_ff,
                                           tx_nib_ff};
          `MMP_OFF_RXHDR: begin
            s_axi_rdata  <= {16'h0, rx_header_status_ff};
            rx_hdr_rd_ff <= 1'b1;
          end
          `MMP_OFF_RXDATA: s_axi_rdata <= {26'h0, invalid_symbol_flag,
                                           rx_nib_new_ff, rx_nib_ff};
          `MMP_OFF_MDCDIV: s_axi_rdata <= {{(32-MDC_DIV_W){1'b0}},
                                           mdc_div_ff};
          default:         s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ==== verification/mmp_monitor.sv ====
/*
  Assertion checker on the medium port's pins.
  Bound to mmp_medium_port; sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module mmp_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        txc,
  input wire logic        txen,
  input wire logic [3:0]  txd,
  input wire logic        mdio_oe_n
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  sequence s_r_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  chk_b_hold: assert property (
    s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_r_hold: assert property (
    s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_aw_block: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  chk_b_code: assert property (
    s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
    else $error("illegal write response code");
  chk_mdio_rel: assert property (mdio_oe_n)
    else $error("management data line driven");
  chk_txd_sync: assert property (
    txen && $changed(txd) |-> !txc)
    else $error("nibble changed away from clock fall");
  chk_txen_rise: assert property ($rose(txen) |-> !txc)
    else $error("enable rose away from clock fall");
endmodule
bind mmp_medium_port mmp_monitor u_mon (
  .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .txc, .txen, .txd, .mdio_oe_n);
`default_nettype wire

// ==== verification/mmp_phy_model.sv ====
/*
  Behavioural PHY and detect-pin model for the medium port bench.
  Assumes the bench calls frame() and hit() and drives aui and mau.
*/
`timescale 1ns/1ps
`default_nettype none
module mmp_phy_model (
  output var logic       txc,
  output var logic       rxc,
  output var logic [3:0] rxd,
  output var logic       rxdv,
  output var logic       rxer,
  output var logic       col,
  input  wire logic      aui,
  input  wire logic      mau
);
  logic [3:0] nib;
  logic [3:0] idle;
  initial begin
    txc = 1'b0;
    #7;
    forever #200 txc = ~txc;
  end
  initial begin
    rxc = 1'b0;
    #19;
    forever #200 rxc = ~rxc;
  end
  initial begin
    rxdv = 1'b0;
    rxer = 1'b0;
    col = 1'b0;
    nib = 4'h0;
    idle = 4'h5;
  end
  // Idle lines flip each cycle
  always @(negedge rxc)
    idle <= ~idle;
  always_comb
    rxd = rxdv ? nib
               : (aui ? {idle[3:1], mau === 1'b1} : idle);
  task frame(input logic [3:0] n, input logic err);
    @(negedge rxc);
    nib = n;
    rxdv = 1'b1;
    rxer = err;
    @(negedge rxc);
    nib = ~n;
    rxer = 1'b0;
    @(negedge rxc);
    rxdv = 1'b0;
  endtask
  // Collision level changes with the transmit clock
  task hit(input logic c);
    @(negedge txc);
    col = c;
  endtask
endmodule
`default_nettype wire

// ==== verification/mmp_medium_port_tb.sv ====
/*
  Self-checking bench for mmp_medium_port.
  Assumes the PHY model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mmp_consts.vh"
module mmp_medium_port_tb;
  logic        aclk, aresetn, awv, wv, bry, arv, rry, awr, wrd, bv, arr, rv;
  logic        lnk, dup, utp, aui, mau, coax, mdc, msel, usel;
  logic        txc, txen, rxc, rxdv, rxer, col;
  logic        acol, mdo, moe, lag;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdt, d;
  logic [3:0]  txd, rxd;
  logic [1:0]  br, rr, r;
  int          errors, n_checks;
  mmp_medium_port uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .txc(txc), .txen(txen), .txd(txd), .rxc(rxc),
    .rxd(rxd), .rxdv(rxdv), .rxer(rxer), .col(col),
    .ext_phy_link_state(lnk), .ext_phy_duplex_state(dup),
    .utp_link(utp), .attach_collision(acol), .mdc(mdc),
    .mdio_in(1'b1), .mdio_out(mdo), .mdio_oe_n(moe),
    .medium_mii_sel(msel), .medium_utp_sel(usel));
  mmp_phy_model phy (.txc(txc), .rxc(rxc), .rxd(rxd), .rxdv(rxdv),
    .rxer(rxer), .col(col), .aui(aui), .mau(mau));
  always_comb
    coax = txd[0];
  task conclude;
    $display("errors=%0d n_checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task tmo(input int i);
    if (i >= 100) begin
      chk(32'h0, 32'h1);
      conclude();
    end
  endtask
  task automatic wt(ref logic s, input logic e);
    int i;
    for (i = 0; i < 100 && s !== e; i++)
      @(posedge aclk);
    tmo(i);
  endtask
  // Cycles spent high from now if already high, else from the next rise
  task automatic hi(ref logic s, input int e);
    int n;
    wt(s, 1'b1);
    for (n = 0; n < 100 && s === 1'b1; n++)
      @(posedge aclk);
    chk(n, e);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    int i;
    @(posedge aclk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= !lag;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wrd === 1'b1) wv <= 1'b0;
      if (bv === 1'b1 && bry === 1'b1) break;
      if (bv === 1'b1) bry <= 1'b1;
    end
    bry <= 1'b0;
    tmo(i);
    chk(br, `MMP_RESP_OKAY);
  endtask
  task rd(input logic [7:0] a);
    int i;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rry <= !lag;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (arr === 1'b1) arv <= 1'b0;
      if (rv === 1'b1 && rry === 1'b1) break;
      if (rv === 1'b1) rry <= 1'b1;
    end
    rry <= 1'b0;
    d = rdt;
    r = rr;
    tmo(i);
  endtask
  task t_reset;
    chk(txen, 1'b0);
    chk({moe, mdo}, 2'h2);
    // Late ready: response must wait for the master
    lag = 1'b1;
    rd(`MMP_OFF_CFG3);
    chk(d, `MMP_CFG3_RESET);
    rd(`MMP_OFF_MDCDIV);
    chk(d, `MMP_MDC_DIV_RESET);
    wr(`MMP_OFF_MDCDIV, 32'h4);
    lag = 1'b0;
    rd(8'h40);
    chk(r, `MMP_RESP_SLVERR);
    chk(d, 32'h0);
  endtask
  task t_coax;
    wr(`MMP_OFF_MEDIUM, 32'h11);
    wt(coax, 1'b1);
    rd(`MMP_OFF_STATUS);
    chk(d[6], 1'b1);
    acol <= 1'b1;
    rd(`MMP_OFF_STATUS);
    rd(`MMP_OFF_STATUS);
    chk(d[4], 1'b1);
    acol <= 1'b0;
    wr(`MMP_OFF_TXCTL, 32'h15);
    repeat (20) @(posedge aclk);
    chk(txen, 1'b0);
    wr(`MMP_OFF_TXCTL, 32'h0);
    mau <= 1'b1;
    wt(coax, 1'b0);
    chk(coax, 1'b0);
    wr(`MMP_OFF_MEDIUM, 32'h10);
    mau <= 1'b0;
    wt(coax, 1'b1);
    chk(coax, 1'b1);
    utp <= 1'b1;
    wt(coax, 1'b0);
    chk(coax, 1'b0);
    phy.frame(4'h3, 1'b1);
    rd(`MMP_OFF_RXHDR);
    chk(d[5], 1'b0);
  endtask
  task t_status;
    aui <= 1'b0;
    wr(`MMP_OFF_CFG3, 32'h2);
    lnk <= 1'b1;
    rd(`MMP_OFF_STATUS);
    rd(`MMP_OFF_STATUS);
    chk({usel, msel, d[1:0]}, 4'h9);
    lnk <= 1'b0;
    dup <= 1'b1;
    rd(`MMP_OFF_STATUS);
    rd(`MMP_OFF_STATUS);
    chk(d[1:0], 2'h2);
    lnk <= 1'b1;
    utp <= 1'b0;
    rd(`MMP_OFF_STATUS);
    rd(`MMP_OFF_STATUS);
    chk({usel, msel}, 2'h1);
    // Forced media override the automatic choice
    wr(`MMP_OFF_MEDIUM, 32'h12);
    rd(`MMP_OFF_STATUS);
    chk({usel, msel}, 2'h1);
    wr(`MMP_OFF_MEDIUM, 32'h13);
    rd(`MMP_OFF_STATUS);
    chk({usel, msel}, 2'h2);
    wr(`MMP_OFF_MEDIUM, 32'h10);
  endtask
  task t_rx;
    phy.frame(4'h6, 1'b1);
    rd(`MMP_OFF_RXDATA);
    chk(d[3:0], 4'h9);
    rd(`MMP_OFF_RXHDR);
    chk(d[5], 1'b1);
    rd(`MMP_OFF_RXHDR);
    chk(d[5], 1'b0);
    // At 10 Mb/s a receive error leaves the flag alone
    wr(`MMP_OFF_MEDIUM, 32'h00);
    phy.frame(4'h6, 1'b1);
    rd(`MMP_OFF_RXHDR);
    chk(d[5], 1'b0);
    wr(`MMP_OFF_MEDIUM, 32'h10);
  endtask
  task t_tx;
    wr(`MMP_OFF_TXCTL, 32'h3A);
    wt(txen, 1'b1);
    chk(txd, 4'hA);
    hi(txen, 8);
    // Open-ended frame: collision and busy seen while sending
    wr(`MMP_OFF_TXCTL, 32'h15);
    wt(txen, 1'b1);
    chk(txd, 4'h5);
    phy.hit(1'b1);
    rd(`MMP_OFF_STATUS);
    rd(`MMP_OFF_STATUS);
    chk(d[4:3], 2'h3);
    phy.hit(1'b0);
    wr(`MMP_OFF_TXCTL, 32'h35);
    wt(txen, 1'b0);
    chk(txd, 4'h0);
  endtask
  task t_mdc;
    wt(mdc, 1'b0);
    hi(mdc, 5);
    wr(`MMP_OFF_MDCDIV, 32'h2);
    wt(mdc, 1'b0);
    hi(mdc, 3);
  endtask
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial begin
    aresetn = 1'b0;
    {awv, wv, bry, arv, rry, lnk, dup, utp, mau} = 9'h000;
    aui = 1'b1;
    {acol, lag} = 2'b00;
    awa = 8'h00;
    ara = 8'h00;
    wd = 32'h0;
    errors = 0;
    n_checks = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_coax;
    t_status;
    t_rx;
    t_tx;
    t_mdc;
    conclude();
  end
endmodule
`default_nettype wire
